// ### hdl/tmde_entry.sv
// interrupt entry for translation misses and debug events, with returns
// assumes the pipeline, lookup unit and debug logic share clk_i
`timescale 1ns/1ns

// Function
// (RULE1) data miss when data translation on
// (RULE2) data miss saves instruction and data address
// (RULE3) syndrome: store flag, keep mchk, clear rest
// (RULE4) data miss precise, vector prefix plus 1100
// (RULE5) translation miss saves machine state
// (RULE6) translation miss clears listed enables only
// (RULE7) instruction miss only when executing, translation on
// (RULE8) instruction miss saves address, vector 1200
// (RULE9) classify debug events sync or async
// (RULE10) some debug events save causing address
// (RULE11) value match, completion save following address
// (RULE12) exception debug event saves original vector
// (RULE13) unconditional debug saves next address
// (RULE14) debug saves state, vector prefix plus 2000
// (RULE15) debug clears all enables but mchk
// (RULE16) debug status records event kind
// (RULE17) critical return restores from critical copies
// (RULE18) ordinary return restores from interrupt copies
// (RULE19) instruction miss leaves fault, syndrome alone
module tmde_entry
  import tmde_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire tmde_data_acc_s   data_acc_i,
  input  wire tmde_instr_exec_s instr_exec_i,
  input  wire tmde_dbg_evt_s    dbg_evt_i,
  input  wire logic             rfi_i,
  input  wire logic             rfci_i,
  output tmde_redirect_s        redirect_o,
  output logic      [31:0]      machine_state_o,
  output logic                  irq_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0]        machine_state_r;
  logic [15:0]        vector_prefix_r;
  logic [31:0]        irq_return_addr_r;
  logic [31:0]        irq_saved_state_r;
  logic [31:0]        critical_return_addr_r;
  logic [31:0]        critical_saved_state_r;
  logic [31:0]        data_fault_address_r;
  logic [31:0]        exception_syndrome_r;
  logic [7:0]         debug_status_reg_r;
  logic [EVT_W-1:0]   evt_status_r;
  logic [EVT_W-1:0]   evt_mask_r;
  logic               ack_r;
  logic [31:0]        rd_data_r;
  tmde_redirect_s     redirect_r;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic               bus_req;
  logic               wr_fire;
  logic [31:0]        rd_mux;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  assign bus_req = wb_cyc_i & wb_stb_i;
  // writes land on the edge the master sees ack
  assign wr_fire = bus_req & wb_we_i & ack_r;

  logic [31:0] wmask;
  assign wmask = merge(32'h00000000, 32'hFFFFFFFF, wb_sel_i);

  always_comb begin
    rd_mux = 32'h00000000;
    case (wb_adr_i)
      OFS_MACHINE_STATE: rd_mux = machine_state_r;
      OFS_VECTOR_PREFIX: rd_mux = {16'h0000, vector_prefix_r};
      OFS_IRQ_RET_ADDR:  rd_mux = irq_return_addr_r;
      OFS_IRQ_SAVED:     rd_mux = irq_saved_state_r;
      OFS_CRIT_RET_ADDR: rd_mux = critical_return_addr_r;
      OFS_CRIT_SAVED:    rd_mux = critical_saved_state_r;
      OFS_DATA_FAULT:    rd_mux = data_fault_address_r;
      OFS_SYNDROME:      rd_mux = exception_syndrome_r;
      OFS_DEBUG_STATUS:  rd_mux = {24'h000000, debug_status_reg_r};
      OFS_EVT_STATUS:    rd_mux = {29'h00000000, evt_status_r};
      OFS_EVT_MASK:      rd_mux = {29'h00000000, evt_mask_r};
      default:           rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r     <= 1'b0;
      rd_data_r <= RST_WORD;
    end else begin
      ack_r <= bus_req & ~ack_r;
      if (bus_req & ~ack_r) begin
        rd_data_r <= rd_mux;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_data_r;

  // ----------------------------------------------------------------
  // event decode and priority
  // ----------------------------------------------------------------
  logic dmiss_take;
  logic imiss_take;
  logic dbg_take;
  logic take_dmiss;
  logic take_imiss;
  logic take_dbg;
  logic take_rfi;
  logic take_rfci;
  logic dbg_is_async;

  // lookup result already compares address and process tag
  assign dmiss_take = data_acc_i.valid & ~data_acc_i.hit
                    & machine_state_r[MS_DATA_XLATE_EN];       // [RULE1]
  assign imiss_take = instr_exec_i.valid & instr_exec_i.fetch_miss
                    & machine_state_r[MS_INSTR_XLATE_EN];      // [RULE7]
  assign dbg_take   = dbg_evt_i.valid & machine_state_r[MS_DEBUG_IRQ_EN];

  // critical class first; an older instruction miss beats a data miss
  assign take_dbg   = dbg_take;
  assign take_imiss = imiss_take & ~dbg_take;
  assign take_dmiss = dmiss_take & ~dbg_take & ~imiss_take;
  // a return that meets an entry is dropped; the pipeline replays it
  assign take_rfci  = rfci_i & ~dbg_take & ~imiss_take & ~dmiss_take;
  assign take_rfi   = rfi_i & ~rfci_i & ~dbg_take & ~imiss_take
                    & ~dmiss_take;

  always_comb begin
    case (dbg_evt_i.kind)
      DBG_EXCEPTION: dbg_is_async = 1'b1;                      // [RULE9]
      DBG_UNCOND:    dbg_is_async = 1'b1;                      // [RULE9]
      default:       dbg_is_async = 1'b0;                      // [RULE9]
    endcase
  end

  logic [31:0] dbg_save_addr;

  always_comb begin
    case (dbg_evt_i.kind)
      DBG_BRANCH_TAKEN: dbg_save_addr = dbg_evt_i.cause_addr;  // [RULE10]
      DBG_DATA_ADDR:    dbg_save_addr = dbg_evt_i.cause_addr;  // [RULE10]
      DBG_INSTR_ADDR:   dbg_save_addr = dbg_evt_i.cause_addr;  // [RULE10]
      DBG_TRAP:         dbg_save_addr = dbg_evt_i.cause_addr;  // [RULE10]
      DBG_DATA_VALUE:   dbg_save_addr = dbg_evt_i.next_addr;   // [RULE11]
      DBG_INSTR_DONE:   dbg_save_addr = dbg_evt_i.next_addr;   // [RULE11]
      DBG_EXCEPTION:    dbg_save_addr = dbg_evt_i.exc_vector;  // [RULE12]
      DBG_UNCOND:       dbg_save_addr = dbg_evt_i.next_addr;   // [RULE13]
      default:          dbg_save_addr = dbg_evt_i.cause_addr;
    endcase
  end

  // ----------------------------------------------------------------
  // machine state and vector prefix
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      machine_state_r <= RST_MACHINE_STATE;
    end else if (take_dbg) begin
      machine_state_r <= machine_state_r & ~DEBUG_CLEAR_MASK;  // [RULE15]
    end else if (take_imiss | take_dmiss) begin
      machine_state_r <= machine_state_r & ~MISS_CLEAR_MASK;   // [RULE6]
    end else if (take_rfci) begin
      machine_state_r <= critical_saved_state_r;               // [RULE17]
    end else if (take_rfi) begin
      machine_state_r <= irq_saved_state_r;                    // [RULE18]
    end else if (wr_fire && wb_adr_i == OFS_MACHINE_STATE) begin
      machine_state_r <= merge(machine_state_r, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vector_prefix_r <= RST_VECTOR_PREFIX;
    end else if (wr_fire && wb_adr_i == OFS_VECTOR_PREFIX) begin
      vector_prefix_r <= (vector_prefix_r & ~wmask[15:0])
                       | (wb_dat_i[15:0] & wmask[15:0]);
    end
  end

  // ----------------------------------------------------------------
  // interrupt-class save registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_return_addr_r <= RST_WORD;
      irq_saved_state_r <= RST_WORD;
    end else if (take_dmiss) begin
      irq_return_addr_r <= data_acc_i.instr_addr;              // [RULE2]
      irq_saved_state_r <= machine_state_r;                    // [RULE5]
    end else if (take_imiss) begin
      irq_return_addr_r <= instr_exec_i.instr_addr;            // [RULE8]
      irq_saved_state_r <= machine_state_r;                    // [RULE5]
    end else if (wr_fire) begin
      if (wb_adr_i == OFS_IRQ_RET_ADDR) begin
        irq_return_addr_r <= merge(irq_return_addr_r, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == OFS_IRQ_SAVED) begin
        irq_saved_state_r <= merge(irq_saved_state_r, wb_dat_i, wb_sel_i);
      end
    end
  end

  // instruction misses never touch these two
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_fault_address_r <= RST_WORD;
      exception_syndrome_r <= RST_WORD;
    end else if (take_dmiss) begin
      data_fault_address_r <= data_acc_i.data_addr;            // [RULE2]
      exception_syndrome_r <= RST_WORD;                        // [RULE3]
      exception_syndrome_r[SYN_MCHK_INSTR] <=
        exception_syndrome_r[SYN_MCHK_INSTR];                  // [RULE3]
      // cache zero and invalidate ops arrive flagged as stores
      exception_syndrome_r[SYN_STORE_FAULT] <=
        data_acc_i.is_store;                                   // [RULE3]
    end else if (wr_fire && !take_imiss) begin                 // [RULE19]
      if (wb_adr_i == OFS_DATA_FAULT) begin
        data_fault_address_r <= merge(data_fault_address_r, wb_dat_i,
                                      wb_sel_i);
      end
      if (wb_adr_i == OFS_SYNDROME) begin
        exception_syndrome_r <= merge(exception_syndrome_r, wb_dat_i,
                                      wb_sel_i);
      end
    end
  end

  // ----------------------------------------------------------------
  // critical-class save registers and debug status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      critical_return_addr_r <= RST_WORD;
      critical_saved_state_r <= RST_WORD;
    end else if (take_dbg) begin
      critical_return_addr_r <= dbg_save_addr;
      critical_saved_state_r <= machine_state_r;               // [RULE14]
    end else if (wr_fire) begin
      if (wb_adr_i == OFS_CRIT_RET_ADDR) begin
        critical_return_addr_r <= merge(critical_return_addr_r, wb_dat_i,
                                        wb_sel_i);
      end
      if (wb_adr_i == OFS_CRIT_SAVED) begin
        critical_saved_state_r <= merge(critical_saved_state_r, wb_dat_i,
                                        wb_sel_i);
      end
    end
  end

  // one-hot by kind; a new event wins over a write-one clear
  logic [7:0] dbg_kind_hot;
  logic [7:0] dbg_clr;
  assign dbg_kind_hot = take_dbg ? (8'h01 << dbg_evt_i.kind) : 8'h00;
  assign dbg_clr = (wr_fire && wb_adr_i == OFS_DEBUG_STATUS)
                 ? (wb_dat_i[7:0] & wmask[7:0]) : 8'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      debug_status_reg_r <= 8'h00;
    end else begin
      debug_status_reg_r <= (debug_status_reg_r & ~dbg_clr)
                          | dbg_kind_hot;                      // [RULE16]
    end
  end

  // ----------------------------------------------------------------
  // redirect to the pipeline
  // ----------------------------------------------------------------
  // registered: clean one-cycle pulse to fetch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      redirect_r <= '0;
    end else begin
      redirect_r.valid    <= take_dbg | take_imiss | take_dmiss
                           | take_rfci | take_rfi;
      redirect_r.is_async <= take_dbg & dbg_is_async;          // [RULE9]
      if (take_dbg) begin
        redirect_r.pc <= {vector_prefix_r, VEC_DEBUG};         // [RULE14]
      end else if (take_imiss) begin
        redirect_r.pc <= {vector_prefix_r, VEC_INSTR_MISS};    // [RULE8]
      end else if (take_dmiss) begin
        redirect_r.pc <= {vector_prefix_r, VEC_DATA_MISS};     // [RULE4]
      end else if (take_rfci) begin
        redirect_r.pc <= critical_return_addr_r;               // [RULE17]
      end else if (take_rfi) begin
        redirect_r.pc <= irq_return_addr_r;                    // [RULE18]
      end
    end
  end

  assign redirect_o      = redirect_r;
  assign machine_state_o = machine_state_r;

  // ----------------------------------------------------------------
  // event status, mask and interrupt line
  // ----------------------------------------------------------------
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;

  assign evt_set[EVT_DATA_MISS]  = take_dmiss;
  assign evt_set[EVT_INSTR_MISS] = take_imiss;
  assign evt_set[EVT_DEBUG]      = take_dbg;
  assign evt_clr = (wr_fire && wb_adr_i == OFS_EVT_STATUS)
                 ? (wb_dat_i[EVT_W-1:0] & wmask[EVT_W-1:0])
                 : {EVT_W{1'b0}};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_status_r <= {EVT_W{1'b0}};
    end else begin
      evt_status_r <= (evt_status_r & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_mask_r <= {EVT_W{1'b0}};
    end else if (wr_fire && wb_adr_i == OFS_EVT_MASK) begin
      evt_mask_r <= (evt_mask_r & ~wmask[EVT_W-1:0])
                  | (wb_dat_i[EVT_W-1:0] & wmask[EVT_W-1:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((evt_status_r & ~evt_clr | evt_set) & evt_mask_r);
    end
  end

endmodule

// ### hdl/tmde_pkg.sv
// constants and carriers of the miss and debug entry
// assumes one core clock, synchronous reset and a classic wishbone bus
package tmde_pkg;

  // ----------------------------------------------------------------
  // wishbone register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MACHINE_STATE  = 8'h00;
  localparam logic [7:0] OFS_VECTOR_PREFIX  = 8'h04;
  localparam logic [7:0] OFS_IRQ_RET_ADDR   = 8'h08;
  localparam logic [7:0] OFS_IRQ_SAVED      = 8'h0C;
  localparam logic [7:0] OFS_CRIT_RET_ADDR  = 8'h10;
  localparam logic [7:0] OFS_CRIT_SAVED     = 8'h14;
  localparam logic [7:0] OFS_DATA_FAULT     = 8'h18;
  localparam logic [7:0] OFS_SYNDROME       = 8'h1C;
  localparam logic [7:0] OFS_DEBUG_STATUS   = 8'h20;
  localparam logic [7:0] OFS_EVT_STATUS     = 8'h24;
  localparam logic [7:0] OFS_EVT_MASK       = 8'h28;

  // ----------------------------------------------------------------
  // machine state bit positions (bit 0 is the lsb)
  // ----------------------------------------------------------------
  localparam int MS_AUX_PROC_AVAIL   = 25;
  localparam int MS_AUX_PROC_EXC_EN  = 19;
  localparam int MS_WAIT_ENABLE      = 18;
  localparam int MS_CRITICAL_ENABLE  = 17;
  localparam int MS_EXT_IRQ_ENABLE   = 15;
  localparam int MS_PROBLEM_STATE    = 14;
  localparam int MS_FLOAT_AVAIL      = 13;
  localparam int MS_MCHK_ENABLE      = 12;
  localparam int MS_FLOAT_EXC_LO     = 11;
  localparam int MS_DEBUG_WAIT_EN    = 10;
  localparam int MS_DEBUG_IRQ_EN     = 9;
  localparam int MS_FLOAT_EXC_HI     = 8;
  localparam int MS_INSTR_XLATE_EN   = 5;
  localparam int MS_DATA_XLATE_EN    = 4;

  // bits cleared on a translation miss entry
  localparam logic [31:0] MISS_CLEAR_MASK = 32'h020CED30;
  // debug entry clears every enable but machine check
  localparam logic [31:0] DEBUG_CLEAR_MASK = MISS_CLEAR_MASK | 32'h00020200;

  // ----------------------------------------------------------------
  // syndrome and status layouts
  // ----------------------------------------------------------------
  localparam int SYN_MCHK_INSTR  = 31;
  localparam int SYN_STORE_FAULT = 23;
  localparam int EVT_DATA_MISS   = 0;
  localparam int EVT_INSTR_MISS  = 1;
  localparam int EVT_DEBUG       = 2;
  localparam int EVT_W           = 3;

  // ----------------------------------------------------------------
  // vectors and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_DATA_MISS  = 16'h1100;
  localparam logic [15:0] VEC_INSTR_MISS = 16'h1200;
  localparam logic [15:0] VEC_DEBUG      = 16'h2000;
  localparam logic [31:0] RST_MACHINE_STATE = 32'h00000000;
  localparam logic [15:0] RST_VECTOR_PREFIX = 16'h0000;
  localparam logic [31:0] RST_WORD          = 32'h00000000;

  // ----------------------------------------------------------------
  // debug event kinds
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DBG_BRANCH_TAKEN = 3'b000,
    DBG_DATA_ADDR    = 3'b001,
    DBG_DATA_VALUE   = 3'b010,
    DBG_INSTR_ADDR   = 3'b011,
    DBG_INSTR_DONE   = 3'b100,
    DBG_TRAP         = 3'b101,
    DBG_EXCEPTION    = 3'b110,
    DBG_UNCOND       = 3'b111
  } tmde_dbg_kind_e;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        hit;
    logic        is_store;
    logic [31:0] instr_addr;
    logic [31:0] data_addr;
  } tmde_data_acc_s;

  typedef struct packed {
    logic        valid;
    logic        fetch_miss;
    logic [31:0] instr_addr;
  } tmde_instr_exec_s;

  typedef struct packed {
    logic           valid;
    tmde_dbg_kind_e kind;
    logic [31:0]    cause_addr;
    logic [31:0]    next_addr;
    logic [31:0]    exc_vector;
  } tmde_dbg_evt_s;

  typedef struct packed {
    logic        valid;
    logic        is_async;
    logic [31:0] pc;
  } tmde_redirect_s;

endpackage

// ### dv/tmde_core_model.sv
// far-side model: pipeline, lookup unit and debug-event logic
// assumes the bench calls one task at a time; each gives one pulse
`timescale 1ns/1ns
module tmde_core_model
  import tmde_pkg::*;
(
  input  wire logic       clk_i,
  output tmde_data_acc_s   data_acc_o,
  output tmde_instr_exec_s instr_exec_o,
  output tmde_dbg_evt_s    dbg_evt_o,
  output logic             rfi_o,
  output logic             rfci_o
);
  initial begin
    data_acc_o = '0;
    instr_exec_o = '0;
    dbg_evt_o = '0;
    rfi_o = 1'b0;
    rfci_o = 1'b0;
  end
  // ----------------------------------------------------------------
  // idle event fields inverted and return strobes cleared so no stale value looks live
  // ----------------------------------------------------------------
  task automatic data_access(input logic h, s, input logic [31:0] i, d);
    @(posedge clk_i);
    data_acc_o <= '{1'b1, h, s, i, d};
    @(posedge clk_i);
    data_acc_o <= tmde_data_acc_s'(~data_acc_o);
  endtask
  task automatic exec(input logic m, input logic [31:0] i);
    @(posedge clk_i);
    instr_exec_o <= '{1'b1, m, i};
    @(posedge clk_i);
    instr_exec_o <= tmde_instr_exec_s'(~instr_exec_o);
  endtask
  task automatic debug(input tmde_dbg_kind_e k, input logic [31:0] c, n, x);
    @(posedge clk_i);
    dbg_evt_o <= '{1'b1, k, c, n, x};
    @(posedge clk_i);
    dbg_evt_o <= tmde_dbg_evt_s'(~dbg_evt_o);
  endtask
  task automatic ret(input logic crit);
    @(posedge clk_i);
    rfi_o <= !crit;
    rfci_o <= crit;
    @(posedge clk_i);
    rfi_o <= 1'b0;
    rfci_o <= 1'b0;
  endtask
endmodule

// ### dv/tmde_entry_asserts.sv
// checker of the entry unit, bound to tmde_entry
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module tmde_entry_asserts
  import tmde_pkg::*;
(
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire tmde_data_acc_s   data_acc_i,
  input wire tmde_instr_exec_s instr_exec_i,
  input wire tmde_dbg_evt_s    dbg_evt_i,
  input wire logic             rfi_i,
  input wire logic             rfci_i,
  input wire tmde_redirect_s   redirect_o,
  input wire logic [31:0]      machine_state_o
);
  // ----------------------------------------------------------------
  // taken events, by priority
  // ----------------------------------------------------------------
  localparam logic [31:0] ONE = 32'h1;
  localparam logic [31:0] ALL = 32'h020EFF30;
  localparam logic [31:0] KEEP = (ONE << MS_CRITICAL_ENABLE) |
    (ONE << MS_MCHK_ENABLE) | (ONE << MS_DEBUG_IRQ_EN);
  logic dbg_t, im_t, dm_t, ent_t, asy;
  assign dbg_t = dbg_evt_i.valid & machine_state_o[MS_DEBUG_IRQ_EN];
  assign im_t = instr_exec_i.valid & instr_exec_i.fetch_miss &
    machine_state_o[MS_INSTR_XLATE_EN] & !dbg_t;
  assign dm_t = data_acc_i.valid & !data_acc_i.hit &
    machine_state_o[MS_DATA_XLATE_EN] & !dbg_t & !im_t;
  assign ent_t = dbg_t | im_t | dm_t;
  assign asy = dbg_t & (dbg_evt_i.kind[2:1] == 2'b11);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_dvec;
    dm_t |=> redirect_o.valid && redirect_o.pc[15:0] == 16'h1100;
  endproperty
  a_dvec: assert property (p_dvec)
    else $error("dmiss vector");
  property p_ivec;
    im_t |=> redirect_o.valid && redirect_o.pc[15:0] == 16'h1200;
  endproperty
  a_ivec: assert property (p_ivec)
    else $error("imiss vector");
  property p_gvec;
    dbg_t |=> redirect_o.valid && redirect_o.pc[15:0] == 16'h2000;
  endproperty
  a_gvec: assert property (p_gvec)
    else $error("debug vector");
  property p_miss_ms;
    im_t || dm_t |=> machine_state_o ==
      ($past(machine_state_o) & ~(ALL & ~KEEP));
  endproperty
  a_miss_ms: assert property (p_miss_ms)
    else $error("miss state");
  property p_dbg_ms;
    dbg_t |=> machine_state_o ==
      ($past(machine_state_o) & ~(ALL & ~(ONE << MS_MCHK_ENABLE)));
  endproperty
  a_dbg_ms: assert property (p_dbg_ms)
    else $error("debug state");
  property p_async;
    asy |=> redirect_o.is_async;
  endproperty
  a_async: assert property (p_async)
    else $error("not async");
  property p_sync;
    ent_t && !asy |=> !redirect_o.is_async;
  endproperty
  a_sync: assert property (p_sync)
    else $error("not sync");
  property p_quiet;
    !ent_t && !rfi_i && !rfci_i |=> !redirect_o.valid;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("stray redirect");
  property p_ret;
    !ent_t && (rfi_i || rfci_i) |=> redirect_o.valid;
  endproperty
  a_ret: assert property (p_ret)
    else $error("return lost");
  c_dmiss: cover property (dm_t);
  c_imiss: cover property (im_t);
  c_uncond: cover property (dbg_t && dbg_evt_i.kind == DBG_UNCOND);
endmodule
bind tmde_entry tmde_entry_asserts i_chk (
  .clk_i, .rst_i, .data_acc_i, .instr_exec_i, .dbg_evt_i,
  .rfi_i, .rfci_i, .redirect_o, .machine_state_o
);

// ### dv/tmde_entry_bench.sv
// testbench for the miss and debug entry unit
// assumes the far-side model drives all event inputs
`timescale 1ns/1ns
module tmde_entry_bench
  import tmde_pkg::*;
();
  // all enables; clear masks from kept bits
  localparam logic [31:0] FULL = 32'h020EFF30;
  localparam logic [31:0] MCLR = FULL & ~32'h00021200;
  localparam logic [31:0] DCLR = FULL & ~32'h00001000;
  localparam logic [15:0] PFX  = 16'hABCD;
  logic             clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, irq;
  logic             rfi, rfci;
  logic [3:0]       wb_sel;
  logic [7:0]       wb_adr;
  logic [31:0]      wb_wdat, wb_rdat, ms, rd, exp;
  tmde_data_acc_s   da;
  tmde_instr_exec_s ie;
  tmde_dbg_evt_s    de;
  tmde_redirect_s   rdr;
  int               errors, comparisons;
  tmde_core_model i_core (.clk_i(clk_i), .data_acc_o(da),
    .instr_exec_o(ie), .dbg_evt_o(de), .rfi_o(rfi), .rfci_o(rfci));
  tmde_entry i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .data_acc_i(da), .instr_exec_i(ie),
    .dbg_evt_i(de), .rfi_i(rfi), .rfci_i(rfci), .redirect_o(rdr),
    .machine_state_o(ms), .irq_o(irq));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] e, g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // classic cycle, bounded wait for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {wb_cyc, wb_stb} <= 2'b11;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rd = wb_rdat;
    {wb_cyc, wb_stb} <= 2'b00;
    if (wb_ack !== 1'b1) begin
      errors++;
      finish_test();
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  // redirect: cycle after take
  task automatic redir(input logic [31:0] pc, input logic as);
    @(posedge clk_i);
    chk("redirect", {30'h0, 1'b1, as, pc}, {30'h0, rdr});
  endtask
  task automatic quiet();
    @(posedge clk_i);
    chk("quiet", 64'h0, {63'h0, rdr.valid});
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    comparisons = 0;
    rst_i = 1'b1;
    {wb_cyc, wb_stb, wb_we} = 3'b000;
    wb_adr = 8'h00;
    wb_wdat = 32'h0;
    wb_sel = 4'hF;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a <= 40; a += 4) rchk("reset", 8'(a), 32'h0);
    wb(1'b1, 8'h40, 32'hFFFFFFFF);
    rchk("unmapped", 8'h40, 32'h0);
    wb(1'b1, OFS_VECTOR_PREFIX, {16'h0, PFX});
    wb(1'b1, OFS_EVT_MASK, 32'h7);
    i_core.data_access(1'b0, 1'b0, 32'h100, 32'h5000);
    quiet();
    for (int s = 1; s >= 0; s--) begin
      wb(1'b1, OFS_MACHINE_STATE, FULL);
      wb(1'b1, OFS_SYNDROME, 32'hFFFFFFFF);
      i_core.data_access(1'b1, 1'b1, 32'h104, 32'h5000);
      quiet();
      i_core.data_access(1'b0, s[0], 32'h100, 32'h5004);
      redir({PFX, 16'h1100}, 1'b0);
      rchk("ret addr", OFS_IRQ_RET_ADDR, 32'h100);
      rchk("fault addr", OFS_DATA_FAULT, 32'h5004);
      rchk("syndrome", OFS_SYNDROME, {8'h80, s[0], 23'h0});
      rchk("saved", OFS_IRQ_SAVED, FULL);
      chk("state", FULL & ~MCLR, ms);
      chk("irq", 64'h1, {63'h0, irq});
      i_core.ret(1'b0);
      redir(32'h100, 1'b0);
      chk("state", FULL, ms);
    end
    wb(1'b1, OFS_MACHINE_STATE, FULL & ~(32'h1 << MS_INSTR_XLATE_EN));
    i_core.exec(1'b1, 32'h200);
    quiet();
    wb(1'b1, OFS_MACHINE_STATE, FULL);
    i_core.exec(1'b0, 32'h200);
    quiet();
    i_core.exec(1'b1, 32'h200);
    redir({PFX, 16'h1200}, 1'b0);
    rchk("ret addr", OFS_IRQ_RET_ADDR, 32'h200);
    rchk("fault addr", OFS_DATA_FAULT, 32'h5004);
    rchk("syndrome", OFS_SYNDROME, 32'h80000000);
    rchk("saved", OFS_IRQ_SAVED, FULL);
    chk("state", FULL & ~MCLR, ms);
    for (int k = 0; k < 8; k++) begin
      wb(1'b1, OFS_MACHINE_STATE, FULL);
      wb(1'b1, OFS_DEBUG_STATUS, 32'hFF);
      i_core.debug(tmde_dbg_kind_e'(k), 32'h300, 32'h304, 32'h700);
      exp = (k == 6) ? 32'h700 : (k inside {2, 4, 7}) ? 32'h304 : 32'h300;
      redir({PFX, 16'h2000}, k >= 6);
      rchk("crit ret", OFS_CRIT_RET_ADDR, exp);
      rchk("crit saved", OFS_CRIT_SAVED, FULL);
      chk("state", FULL & ~DCLR, ms);
      rchk("dbg status", OFS_DEBUG_STATUS, 32'h1 << k);
      i_core.ret(1'b1);
      redir(exp, 1'b0);
      chk("state", FULL, ms);
    end
    rchk("events", OFS_EVT_STATUS, 32'h7);
    wb(1'b1, OFS_EVT_MASK, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("irq masked", 64'h0, {63'h0, irq});
    wb(1'b1, OFS_EVT_MASK, 32'h7);
    wb(1'b1, OFS_EVT_STATUS, 32'h7);
    rchk("evt clr", OFS_EVT_STATUS, 32'h0);
    chk("irq clr", 64'h0, {63'h0, irq});
    finish_test();
  end
endmodule
